// ==== rtl/cpc_pkg.sv ====
package cpc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int FAULT_PULSE_US = 128;
  localparam int FAULT_PULSE_CYC = FAULT_PULSE_US * CLK_MHZ;
  localparam int PULSE_CNT_W = 16;

  // ----------------------------------------------------------------
  // Input current limit codes and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CPC_ILIM_100MA = 2'h0,
    CPC_ILIM_1500MA = 2'h1
  } cpc_ilim_t;

  localparam cpc_ilim_t ILIM_RESET = CPC_ILIM_100MA;
  localparam logic [1:0] TS_FAULT_RESET = 2'h0;

  typedef enum logic [1:0] {
    CPC_TS_NORMAL = 2'h0,
    CPC_TS_WARM = 2'h1,
    CPC_TS_COOL = 2'h2,
    CPC_TS_COLD = 2'h3
  } cpc_ts_t;

  // Comparator results from the analog front end.
  typedef struct packed {
    logic in_present;
    logic above_uvlo;
    logic above_sleep;
  } cpc_supply_t;

  // Four thermistor comparators, each high when its threshold is crossed.
  typedef struct packed {
    logic cold;
    logic cool;
    logic warm;
    logic hot;
  } cpc_therm_t;

endpackage

// ==== rtl/cpc_top.sv ====
`timescale 1ns/1ps
module cpc_top
  import cpc_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Variant and pins
  input wire logic VARIANT_PSEL,
  input wire logic HW_DISABLE_INPUT,
  input wire logic SOURCE_SELECT,
  input wire logic DPDM_SHORT,
  // Analog comparators
  input wire cpc_supply_t SUPPLY,
  input wire cpc_therm_t PACK_THERMISTOR_INPUT,
  // Charger core
  input wire logic CYCLE_START,
  input wire logic CHARGING,
  input wire logic CHARGE_DONE,
  input wire logic FAULT,
  input wire logic STAT_ENABLE,
  // Outputs
  output logic HIZ_MODE,
  output cpc_ilim_t INPUT_ILIM,
  output logic USB_LOW_CURRENT_MODE,
  output logic GATE_DRIVE_SUPPLY,
  output logic DISCHARGE_FET_GATE,
  output logic STAT_OUT,
  output logic STAT_OE,
  output logic INT_OUT,
  output logic INT_OE,
  output cpc_ts_t TS_FAULT
);

  // ----------------------------------------------------------------
  // Supply qualification
  // ----------------------------------------------------------------
  wire logic supply_ok = SUPPLY.in_present & SUPPLY.above_uvlo & SUPPLY.above_sleep;
  wire logic hiz = HW_DISABLE_INPUT;

  // ----------------------------------------------------------------
  // Input current limit selection
  // ----------------------------------------------------------------
  // The D+/D- result is only meaningful on the detection variant.
  wire cpc_ilim_t ilim_dpdm = DPDM_SHORT ? CPC_ILIM_1500MA : CPC_ILIM_100MA;
  wire cpc_ilim_t ilim_psel = SOURCE_SELECT ? CPC_ILIM_100MA : CPC_ILIM_1500MA;
  wire cpc_ilim_t ilim_pick = VARIANT_PSEL ? ilim_psel : ilim_dpdm;
  wire logic sample_now = CYCLE_START & ~hiz;
  cpc_ilim_t ilim_q;
  wire cpc_ilim_t ilim_d = sample_now ? ilim_pick : ilim_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ilim_q <= ILIM_RESET;
    end else begin
      ilim_q <= ilim_d;
    end
  end

  // ----------------------------------------------------------------
  // Fault pulse timer
  // ----------------------------------------------------------------
  // A fault during a running pulse restarts it, so while STAT_ENABLE is high
  // the host sees at least the full width after the latest fault.
  localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(FAULT_PULSE_CYC);
  logic [PULSE_CNT_W-1:0] pulse_q;
  logic fault_q;
  wire logic fault_rise = FAULT & ~fault_q;
  wire logic pulse_on = pulse_q != '0;
  wire logic [PULSE_CNT_W-1:0] pulse_d = fault_rise ? PULSE_LOAD :
                                         (pulse_on ? pulse_q - 1'b1 : pulse_q);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pulse_q <= '0;
      fault_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
      fault_q <= FAULT;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  wire logic charging_low = CHARGING & ~CHARGE_DONE & ~hiz;
  wire logic stat_low_d = STAT_ENABLE & (charging_low | pulse_on);
  logic stat_low_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      stat_low_q <= 1'b0;
    end else begin
      stat_low_q <= stat_low_d;
    end
  end

  assign STAT_OUT = 1'b0;
  assign STAT_OE = stat_low_q;
  assign INT_OUT = 1'b0;
  assign INT_OE = stat_low_q;

  // ----------------------------------------------------------------
  // Supply, gate and thermistor outputs
  // ----------------------------------------------------------------
  logic drv_q;
  logic discharge_fet_gate_q;
  cpc_ts_t ts_q;
  wire cpc_ts_t ts_d = PACK_THERMISTOR_INPUT.cold ? CPC_TS_COLD :
                       PACK_THERMISTOR_INPUT.cool ? CPC_TS_COOL :
                       (PACK_THERMISTOR_INPUT.warm | PACK_THERMISTOR_INPUT.hot) ? CPC_TS_WARM :
                       CPC_TS_NORMAL;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      drv_q <= 1'b0;
      discharge_fet_gate_q <= 1'b0;
      ts_q <= cpc_ts_t'(TS_FAULT_RESET);
    end else begin
      drv_q <= supply_ok;
      discharge_fet_gate_q <= supply_ok & SUPPLY.in_present & ~hiz;
      ts_q <= ts_d;
    end
  end

  assign HIZ_MODE = hiz;
  assign INPUT_ILIM = ilim_q;
  assign USB_LOW_CURRENT_MODE = ilim_q == CPC_ILIM_100MA;
  assign GATE_DRIVE_SUPPLY = drv_q;
  assign DISCHARGE_FET_GATE = discharge_fet_gate_q;
  assign TS_FAULT = ts_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_dpdm_short_limit: assert property (sample_now && !VARIANT_PSEL && DPDM_SHORT |=> INPUT_ILIM == CPC_ILIM_1500MA)
    else $error("short did not select high limit");
  a_dpdm_open_low: assert property (sample_now && !VARIANT_PSEL && !DPDM_SHORT |=> USB_LOW_CURRENT_MODE)
    else $error("no short did not select low mode");
  a_hiz_follow: assert property (HIZ_MODE == HW_DISABLE_INPUT)
    else $error("hiz mode does not follow disable pin");
  a_psel_usb: assert property (sample_now && VARIANT_PSEL && SOURCE_SELECT |=> INPUT_ILIM == CPC_ILIM_100MA)
    else $error("usb source not 100 mA");
  a_psel_adapter: assert property (sample_now && VARIANT_PSEL && !SOURCE_SELECT |=> INPUT_ILIM == CPC_ILIM_1500MA)
    else $error("adapter not 1.5 A");
  a_discharge_fet_gate_low: assert property (HW_DISABLE_INPUT || !SUPPLY.in_present |=> !DISCHARGE_FET_GATE)
    else $error("discharge gate high while disabled");
  a_stat_charging: assert property (STAT_ENABLE && CHARGING && !CHARGE_DONE && !HW_DISABLE_INPUT |=> STAT_OE)
    else $error("status not low while charging");
  a_stat_release: assert property ((CHARGE_DONE || HW_DISABLE_INPUT) && !pulse_on |=> !STAT_OE)
    else $error("status not released");
  a_fault_pulse: assert property (fault_rise && STAT_ENABLE [*3] |=> STAT_OE [*8])
    else $error("fault pulse too short");
  a_fault_width: assert property (fault_rise |=> pulse_q == PULSE_LOAD)
    else $error("fault pulse width wrong");
  a_stat_enable: assert property (!STAT_ENABLE |=> !STAT_OE)
    else $error("status driven while disabled");
  a_int_mirror: assert property (INT_OE == STAT_OE)
    else $error("interrupt output differs");
  a_drv_gate: assert property (GATE_DRIVE_SUPPLY |-> $past(supply_ok))
    else $error("gate drive on without supply");
  a_ts_cold: assert property (PACK_THERMISTOR_INPUT.cold |=> TS_FAULT == CPC_TS_COLD)
    else $error("cold not reported");
  a_ts_cool: assert property (!PACK_THERMISTOR_INPUT.cold && PACK_THERMISTOR_INPUT.cool |=> TS_FAULT == CPC_TS_COOL)
    else $error("cool not reported");
  a_ilim_mode: assert property (USB_LOW_CURRENT_MODE == (INPUT_ILIM == CPC_ILIM_100MA))
    else $error("low current mode disagrees with limit");
  a_od_data: assert property (!STAT_OUT && !INT_OUT)
    else $error("open drain data not low");
  a_ilim_hold: assert property (!sample_now |=> $stable(INPUT_ILIM))
    else $error("limit changed mid cycle");

  c_short_start: cover property (sample_now && DPDM_SHORT && !VARIANT_PSEL);
  c_fault_pulse: cover property (fault_rise && STAT_ENABLE);
  c_charge_done: cover property (STAT_OE ##1 !STAT_OE);
  c_hiz_entry: cover property (!HW_DISABLE_INPUT ##1 HW_DISABLE_INPUT);

endmodule // cpc_top

// ==== verif/cpc_host_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the two open-drain status lines
// ----------------------------------------------------------------
module cpc_host_model (
  // Open-drain drivers
  input wire logic stat_out,
  input wire logic stat_oe,
  input wire logic int_out,
  input wire logic int_oe,
  // Resolved lines
  output logic stat_line,
  output logic int_line
);
  // The pull-ups set the level whenever nothing pulls a line low.
  assign stat_line = stat_oe ? stat_out : 1'b1;
  assign int_line = int_oe ? int_out : 1'b1;
endmodule // cpc_host_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module tb;
  import cpc_pkg::*;
  logic clk, rst_n, psel, dis, src, shrt, cs, chg, done, flt, sten;
  logic hiz, usbl, gds, fet, so, soe, io, ioe, s_line, i_line;
  cpc_supply_t sup;
  cpc_therm_t th;
  cpc_ilim_t ilim;
  cpc_ts_t ts;
  int n_fail, checks, k;
  cpc_top dut (.CLOCK(clk), .RST_N(rst_n), .VARIANT_PSEL(psel), .HW_DISABLE_INPUT(dis),
    .SOURCE_SELECT(src), .DPDM_SHORT(shrt), .SUPPLY(sup), .PACK_THERMISTOR_INPUT(th),
    .CYCLE_START(cs), .CHARGING(chg), .CHARGE_DONE(done), .FAULT(flt), .STAT_ENABLE(sten),
    .HIZ_MODE(hiz), .INPUT_ILIM(ilim), .USB_LOW_CURRENT_MODE(usbl), .GATE_DRIVE_SUPPLY(gds),
    .DISCHARGE_FET_GATE(fet), .STAT_OUT(so), .STAT_OE(soe), .INT_OUT(io), .INT_OE(ioe),
    .TS_FAULT(ts));
  cpc_host_model host (.stat_out(so), .stat_oe(soe), .int_out(io), .int_oe(ioe),
    .stat_line(s_line), .int_line(i_line));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task start;
    @(posedge clk) cs <= 1'b1;
    @(posedge clk) cs <= 1'b0;
    cyc(2);
  endtask
  task t_dpdm;
    @(posedge clk) shrt <= 1'b1;
    start;
    `CHK(ilim, CPC_ILIM_1500MA)
    `CHK(usbl, 1'b0)
    @(posedge clk) shrt <= 1'b0;
    cyc(3);
    `CHK(ilim, CPC_ILIM_1500MA)
    start;
    `CHK(usbl, 1'b1)
    $display("test dpdm done");
  endtask
  task t_psel;
    @(posedge clk) psel <= 1'b1;
    start;
    `CHK(ilim, CPC_ILIM_1500MA)
    @(posedge clk) src <= 1'b1;
    start;
    `CHK(ilim, CPC_ILIM_100MA)
    $display("test psel done");
  endtask
  task t_hiz;
    @(posedge clk) src <= 1'b0;
    dis <= 1'b1;
    start;
    `CHK(hiz, 1'b1)
    `CHK(ilim, CPC_ILIM_100MA)
    `CHK(fet, 1'b0)
    @(posedge clk) dis <= 1'b0;
    cyc(2);
    `CHK(fet, 1'b1)
    @(posedge clk) sup.above_sleep <= 1'b0;
    cyc(2);
    `CHK(gds, 1'b0)
    @(posedge clk) sup <= 3'h3;
    cyc(2);
    `CHK(fet, 1'b0)
    @(posedge clk) sup <= 3'h7;
    cyc(2);
    `CHK(gds, 1'b1)
    $display("test hiz done");
  endtask
  task t_stat;
    @(posedge clk) chg <= 1'b1;
    cyc(2);
    `CHK(s_line, 1'b0)
    `CHK(i_line, 1'b0)
    `CHK({so, io}, 2'h0)
    @(posedge clk) sten <= 1'b0;
    cyc(2);
    `CHK(s_line, 1'b1)
    @(posedge clk) sten <= 1'b1;
    done <= 1'b1;
    cyc(2);
    `CHK(s_line, 1'b1)
    `CHK(i_line, 1'b1)
    @(posedge clk) done <= 1'b0;
    dis <= 1'b1;
    cyc(2);
    `CHK(s_line, 1'b1)
    @(posedge clk) dis <= 1'b0;
    chg <= 1'b0;
    $display("test stat done");
  endtask
  task t_fault;
    @(posedge clk) flt <= 1'b1;
    k = 0;
    cyc(1);
    while (s_line !== 1'b0 && k < 5) begin
      cyc(1);
      k++;
    end
    `CHK(i_line, 1'b0)
    k = 0;
    while (s_line === 1'b0 && k < 30000) begin
      cyc(1);
      k++;
    end
    `CHK(k, FAULT_PULSE_CYC)
    @(posedge clk) flt <= 1'b0;
    $display("test fault done");
  endtask
  task t_therm;
    @(posedge clk) th <= 4'h8;
    cyc(2);
    `CHK(ts, CPC_TS_COLD)
    @(posedge clk) th <= 4'h1;
    cyc(2);
    `CHK(ts, CPC_TS_WARM)
    @(posedge clk) th <= 4'h4;
    cyc(2);
    `CHK(ts, CPC_TS_COOL)
    $display("test therm done");
  endtask
  task summarize;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, psel, dis, src, shrt, cs, chg, done, flt, th} = '0;
    sten = 1'b1;
    sup = 3'h7;
    cyc(19);
    `CHK(usbl, 1'b1)
    @(posedge clk) rst_n <= 1'b1;
    t_dpdm;
    t_psel;
    t_hiz;
    t_stat;
    t_fault;
    t_therm;
    summarize;
  end
endmodule // tb
